// File: logic/dpll_cfg_map.svh
`ifndef DPLL_CFG_MAP_SVH
`define DPLL_CFG_MAP_SVH

// register offsets on the internal register port
`define PULL_RANGE_HIGH_ADDR   8'h42
`define PREDIV_LOW_ADDR        8'h46
`define PREDIV_HIGH_ADDR       8'h47
`define INSTANCE_SEL_ADDR      8'h4B

// reset values
`define PULL_RANGE_HIGH_RESET  8'h03
`define PREDIV_LOW_RESET       8'hFF
`define PREDIV_HIGH_RESET      8'h3F
`define INSTANCE_SEL_RESET     8'h00

// implemented bits of each register
`define PULL_RANGE_HIGH_MASK   8'h03
`define PREDIV_LOW_MASK        8'hFF
`define PREDIV_HIGH_MASK       8'h3F
`define INSTANCE_SEL_MASK      8'h10

// field positions, divide limit and unmapped read value
`define INSTANCE_SEL_BIT       4
`define PULL_RANGE_FIELD_MSB   1
`define PREDIV_HIGH_FIELD_MSB  5
`define PREDIV_MAX_VALUE       14'h30D2
`define UNMAPPED_READ_VALUE    8'h00

`endif

// File: logic/dpll_cfg_pkg.sv
package dpll_cfg_pkg;

    typedef logic [7:0] reg_byte_t;

    // index of each register cell
    typedef enum logic [1:0] {
        CELL_PULL_RANGE_HIGH = 2'b00,
        CELL_PREDIV_LOW      = 2'b01,
        CELL_PREDIV_HIGH     = 2'b10,
        CELL_INSTANCE_SEL    = 2'b11
    } reg_cell_e;

    localparam int NUM_CELLS = 4;

endpackage : dpll_cfg_pkg

// File: logic/cfg_reg_cell.sv
`timescale 1ns/1ps
module cfg_reg_cell
#(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] BIT_MASK    = 8'hFF
)
(
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    // write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // stored value
    output logic      [7:0] q
);

    logic [7:0] value_reg;
    logic [7:0] value_next;

    // unused bits never store, so they read back as zero
    assign value_next = wr_en ? (wdata & BIT_MASK) : value_reg;
    assign q          = value_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            value_reg <= RESET_VALUE & BIT_MASK;
        else
            value_reg <= value_next;
    end

endmodule : cfg_reg_cell

// File: logic/dpll_divider_config_regs.sv
`timescale 1ns/1ps
`include "dpll_cfg_map.svh"
module dpll_divider_config_regs
    import dpll_cfg_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // register port from serial-port logic
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rd_valid,
    // configuration towards the datapath
    output logic      [1:0]  pll_pull_range_limit_hi,
    output logic      [13:0] input_prediv_value,
    output logic             pll_instance_select_bit,
    output logic             prediv_over_limit
);

    // address decode shared by write and read paths
    function automatic logic [4:0] decode_addr(input logic [7:0] addr);
        logic [4:0] hit;
        hit = 5'h00;
        if (addr == `PULL_RANGE_HIGH_ADDR)
            hit = 5'h01;
        else if (addr == `PREDIV_LOW_ADDR)
            hit = 5'h02;
        else if (addr == `PREDIV_HIGH_ADDR)
            hit = 5'h04;
        else if (addr == `INSTANCE_SEL_ADDR)
            hit = 5'h08;
        else
            hit = 5'h10;
        return hit;
    endfunction : decode_addr

    function automatic logic [7:0] cell_reset(input int idx);
        logic [7:0] r;
        r = `INSTANCE_SEL_RESET;
        if (idx == CELL_PULL_RANGE_HIGH)
            r = `PULL_RANGE_HIGH_RESET;
        else if (idx == CELL_PREDIV_LOW)
            r = `PREDIV_LOW_RESET;
        else if (idx == CELL_PREDIV_HIGH)
            r = `PREDIV_HIGH_RESET;
        return r;
    endfunction : cell_reset

    function automatic logic [7:0] cell_mask(input int idx);
        logic [7:0] m;
        m = `INSTANCE_SEL_MASK;
        if (idx == CELL_PULL_RANGE_HIGH)
            m = `PULL_RANGE_HIGH_MASK;
        else if (idx == CELL_PREDIV_LOW)
            m = `PREDIV_LOW_MASK;
        else if (idx == CELL_PREDIV_HIGH)
            m = `PREDIV_HIGH_MASK;
        return m;
    endfunction : cell_mask

    wire logic [4:0]  wr_hit;
    wire logic [4:0]  rd_hit;
    wire logic [7:0]  cell_q [NUM_CELLS];
    wire logic [7:0]  rd_mux;
    wire logic [13:0] prediv_word;

    logic [7:0]  rdata_reg;
    logic        rd_valid_reg;
    logic [1:0]  pull_hi_reg;
    logic [13:0] prediv_reg;
    logic        inst_sel_reg;
    logic        over_limit_reg;

    // masked reset images; the configuration output flops load only these constants on async reset
    localparam logic [7:0]  PULL_HI_RESET_BYTE   = `PULL_RANGE_HIGH_RESET & `PULL_RANGE_HIGH_MASK;
    localparam logic [7:0]  PREDIV_HI_RESET_BYTE = `PREDIV_HIGH_RESET & `PREDIV_HIGH_MASK;
    localparam logic [7:0]  INST_SEL_RESET_BYTE  = `INSTANCE_SEL_RESET & `INSTANCE_SEL_MASK;
    localparam logic [1:0]  PULL_HI_RESET        = PULL_HI_RESET_BYTE[`PULL_RANGE_FIELD_MSB:0];
    localparam logic [13:0] PREDIV_RESET         = {PREDIV_HI_RESET_BYTE[`PREDIV_HIGH_FIELD_MSB:0],
                                                    `PREDIV_LOW_RESET};
    localparam logic        INST_SEL_RESET       = INST_SEL_RESET_BYTE[`INSTANCE_SEL_BIT];
    localparam logic        OVER_LIMIT_RESET     = (PREDIV_RESET > `PREDIV_MAX_VALUE);

    // next values of the output flops, and the cell write enables
    wire logic [7:0]           rdata_next;
    wire logic                 rd_valid_next;
    wire logic [1:0]           pull_hi_next;
    wire logic [13:0]          prediv_next;
    wire logic                 inst_sel_next;
    wire logic                 over_limit_next;
    wire logic [NUM_CELLS-1:0] cell_wr_en;

    assign wr_hit = decode_addr(reg_addr);
    assign rd_hit = decode_addr(reg_addr);
    assign cell_wr_en = {NUM_CELLS{reg_wr}} & wr_hit[NUM_CELLS-1:0];

    // one cell per register; writes to unmapped offsets fall on no cell
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++)
        begin : g_cell
            cfg_reg_cell #(
                .RESET_VALUE (cell_reset(gi)),
                .BIT_MASK    (cell_mask(gi))
            ) u_cell (
                .sys_clk (sys_clk),
                .rst_n   (rst_n),
                .wr_en   (cell_wr_en[gi]),
                .wdata   (reg_wdata),
                .q       (cell_q[gi])
            );
        end
    endgenerate

    // unused bits are masked in the cells, so they read as zero
    assign rd_mux = rd_hit[CELL_PULL_RANGE_HIGH] ? cell_q[CELL_PULL_RANGE_HIGH] :
                    rd_hit[CELL_PREDIV_LOW]      ? cell_q[CELL_PREDIV_LOW] :
                    rd_hit[CELL_PREDIV_HIGH]     ? cell_q[CELL_PREDIV_HIGH] :
                    rd_hit[CELL_INSTANCE_SEL]    ? cell_q[CELL_INSTANCE_SEL] :
                    `UNMAPPED_READ_VALUE;

    assign prediv_word = {cell_q[CELL_PREDIV_HIGH][`PREDIV_HIGH_FIELD_MSB:0],
                          cell_q[CELL_PREDIV_LOW]};

    // read data holds until the next read, so a slow poller still sees it
    assign rdata_next      = reg_rd ? rd_mux : rdata_reg;
    assign rd_valid_next   = reg_rd;
    assign pull_hi_next    = cell_q[CELL_PULL_RANGE_HIGH][`PULL_RANGE_FIELD_MSB:0];
    assign prediv_next     = prediv_word;
    assign inst_sel_next   = cell_q[CELL_INSTANCE_SEL][`INSTANCE_SEL_BIT];
    // flag only; the device does not clamp the divide value
    assign over_limit_next = (prediv_word > `PREDIV_MAX_VALUE);

    // a write and a read in the same cycle return the old value
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= `UNMAPPED_READ_VALUE;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_valid_reg <= rd_valid_next;
        end
    end

    // outputs re-registered so the datapath sees flop outputs only;
    // this adds one cycle between a write and its effect
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pull_hi_reg <= PULL_HI_RESET;
        end
        else
        begin
            pull_hi_reg <= pull_hi_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prediv_reg <= PREDIV_RESET;
        end
        else
        begin
            prediv_reg <= prediv_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inst_sel_reg <= INST_SEL_RESET;
        end
        else
        begin
            inst_sel_reg <= inst_sel_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            over_limit_reg <= OVER_LIMIT_RESET;
        end
        else
        begin
            over_limit_reg <= over_limit_next;
        end
    end

    assign reg_rdata               = rdata_reg;
    assign reg_rd_valid            = rd_valid_reg;
    assign pll_pull_range_limit_hi = pull_hi_reg;
    assign input_prediv_value      = prediv_reg;
    assign pll_instance_select_bit = inst_sel_reg;
    assign prediv_over_limit       = over_limit_reg;

endmodule : dpll_divider_config_regs

// File: dv/dpll_cfg_properties.sv
`timescale 1ns/1ps
module dpll_cfg_properties
(
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rd_valid,
    // configuration outputs
    input wire logic [1:0]  pll_pull_range_limit_hi,
    input wire logic [13:0] input_prediv_value,
    input wire logic        pll_instance_select_bit,
    input wire logic        prediv_over_limit
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // a lone write; a second write next cycle reaches the output only after this check, two cycles on
    sequence wr_once(a);
        reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
    endsequence
    pull_unused_a: assert property (reg_rd && reg_addr == 8'h42 |=>
        reg_rdata[7:2] == 6'h00)
        else $error("pull range unused bits set");
    pull_write_a: assert property (wr_once(8'h42) |=>
        pll_pull_range_limit_hi == $past(reg_wdata[1:0], 2))
        else $error("pull range output wrong");
    low_write_a: assert property (wr_once(8'h46) |=>
        input_prediv_value[7:0] == $past(reg_wdata, 2))
        else $error("prediv low wrong");
    high_write_a: assert property (wr_once(8'h47) |=>
        input_prediv_value[13:8] == $past(reg_wdata[5:0], 2))
        else $error("prediv high wrong");
    sel_write_a: assert property (wr_once(8'h4B) |=>
        pll_instance_select_bit == $past(reg_wdata[4], 2))
        else $error("select bit wrong");
endmodule : dpll_cfg_properties

bind dpll_divider_config_regs dpll_cfg_properties chk (.sys_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rd_valid, .pll_pull_range_limit_hi,
    .input_prediv_value, .pll_instance_select_bit, .prediv_over_limit);

// File: dv/dpll_divider_config_regs_tb.sv
`timescale 1ns/1ps
module dpll_divider_config_regs_tb;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        reg_rd_valid;
    logic [1:0]  pull_hi;
    logic [13:0] prediv;
    logic        sel;
    logic        over;
    int          miscompares = 0;
    int          comparisons = 0;

    always #2.5 sys_clk = ~sys_clk;

    dpll_divider_config_regs uut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reg_rd_valid, .pll_pull_range_limit_hi(pull_hi),
        .input_prediv_value(prediv), .pll_instance_select_bit(sel), .prediv_over_limit(over));

    task conclude;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
    endtask : wr

    // valid flag stands one cycle only, so it is judged right after the taking edge
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        chk({7'h00, reg_rd_valid, reg_rdata}, {8'h01, exp});
    endtask : rd

    task t_reset;
        rd(8'h42, 8'h03);
        rd(8'h46, 8'hFF);
        rd(8'h47, 8'h3F);
        rd(8'h4B, 8'h00);
        chk({pull_hi, prediv}, 16'hFFFF);
        chk({14'h0000, sel, over}, 16'h0001);
        $display("t_reset end");
    endtask : t_reset

    task t_divider;
        wr(8'h46, 8'hD2);
        wr(8'h47, 8'hF0);
        rd(8'h47, 8'h30);
        chk({1'b0, over, prediv}, 16'h30D2);
        wr(8'h46, 8'hD1);
        rd(8'h46, 8'hD1);
        chk({1'b0, over, prediv}, 16'h30D1);
        $display("t_divider end");
    endtask : t_divider

    task t_pull_sel;
        wr(8'h42, 8'hFE);
        wr(8'h4B, 8'hFF);
        rd(8'h42, 8'h02);
        rd(8'h4B, 8'h10);
        chk({13'h0000, pull_hi, sel}, 16'h0005);
        wr(8'h4B, 8'hEF);
        wr(8'h48, 8'h55);
        rd(8'h48, 8'h00);
        chk({15'h0000, sel}, 16'h0000);
        $display("t_pull_sel end");
    endtask : t_pull_sel

    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_divider;
        t_pull_sel;
        rst_n = 1'b0;
        @(posedge sys_clk) #1 rst_n = 1'b1;
        t_reset;
        conclude;
    end
endmodule : dpll_divider_config_regs_tb
